//--- verilog/asc_sequence_control.v
// converter sequence control with axi4-lite register slave
// Functional notes
// R1 - freeze register write aborts running sequence
// R2 - freeze code 00 keeps converting in debug
// R3 - code 10 finishes conversion then waits
// R4 - code 11 halts at once during debug
// R5 - resolution bit picks 8 or 10 bit
// R6 - sample code gives 2,4,8,16 clocks
// R7 - conversion length per resolution and sample
// R8 - prescaler divides by field plus one, halved
// R9 - prescale resets 00001; 00000 gives two
// R10 - software keeps converter clock in range
// R11 - clock register write aborts until start
// R12 - start write restarts, clears done flags
// R13 - length bit selects four or eight
// R14 - repeat bit selects single or continuous
// R15 - no stepping: one channel, consecutive results
// R16 - stepping walks group, result k stores k
// R17 - channel code maps inputs and references
// R18 - eight-step upper group yields reserved, references
// R19 - sequence flag set at first end
// R20 - result flag set when result loaded
// R21 - results unsigned, left justified in 16
// R22 - reserved freeze code 01 acts as 00
// R23 - conversion counter names next result register
`timescale 1ns/1ps
`include "asc_consts.vh"
module asc_sequence_control (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // debug state of the system
    input wire background_debug_mode,
    // converter core
    input wire [9:0] conv_data,
    output wire conv_clk,
    output reg conv_busy,
    output reg [3:0] conv_channel,
    output reg conv_ten_bit,
    output reg conv_capture,
    // status side
    output reg sequence_done_flag,
    output reg [7:0] result_done_flag
);

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
// map a byte address to a register slot; 4'hF means unmapped
function [3:0] slot_of;
    input [5:0] addr;
    begin
        if (addr[1:0] != 2'h0 || addr > `ASC_OFF_LAST)
            slot_of = 4'hF;
        else
            // one slot per aligned word from 0x00 up to 0x2C
            slot_of = addr[5:2];
    end
endfunction

// total converter clocks of one conversion
function [5:0] conv_len;
    input ten;
    input [1:0] smp;
    begin
        conv_len = (ten ? `ASC_BASE_10BIT : `ASC_BASE_8BIT) // R5 R7
            + (`ASC_SMP_MIN << smp); // R6
    end
endfunction

// ----------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------
localparam ST_IDLE = 2'h0; // no sequence
localparam ST_RUN = 2'h1; // converting
localparam ST_PAUSE = 2'h2; // parked between conversions in debug

reg [7:0] freeze_reg; // debug_freeze_control
reg [7:0] clkres_reg; // clock_resolution_control
reg [7:0] start_reg; // sequence_start_control
reg [15:0] result_reg [0:7]; // result_register array
reg [1:0] state_reg; // sequencer state
reg [1:0] state_next;
reg [2:0] count_reg; // conversion counter
reg [5:0] clk_cnt_reg; // converter clocks into this conversion
// axi holding
reg aw_hold_reg;
reg [5:0] aw_addr_reg;
reg w_hold_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;

wire conv_tick; // one pulse per converter clock period
wire do_write; // address and data both held
wire [3:0] wr_slot;
wire [3:0] rd_slot;
wire wr_freeze;
wire wr_clkres;
wire wr_start;
wire rd_take;
wire [1:0] frz_code;
wire halt_now;
wire conv_end;
wire last_conv;
wire [5:0] len;
integer i;

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
asc_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .prescale(clkres_reg[`ASC_PRS_HI:`ASC_PRS_LO]),
    .conv_clk_reg(conv_clk),
    .conv_tick_reg(conv_tick)
);

// ----------------------------------------------------------------
// axi write path
// ----------------------------------------------------------------
// one write at a time: both channels close while a response waits
assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
assign wr_slot = slot_of(aw_addr_reg);
// only byte lane zero carries the 8-bit control registers
assign wr_freeze = do_write && w_strb_reg[0] && wr_slot == 4'h0;
assign wr_clkres = do_write && w_strb_reg[0] && wr_slot == 4'h1;
assign wr_start = do_write && w_strb_reg[0] && wr_slot == 4'h2;

// address and data are captured in either order, then answered
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_reg <= 1'b0;
        aw_addr_reg <= 6'h00;
        w_hold_reg <= 1'b0;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `ASC_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // status and results are read-only, so they refuse writes
            s_axi_bresp <= (wr_slot <= 4'h2) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// control registers
always @(posedge aclk) begin
    if (!aresetn) begin
        freeze_reg <= `ASC_RST_FREEZE;
        clkres_reg <= `ASC_RST_CLKRES; // R9
        start_reg <= `ASC_RST_START;
    end else begin
        // upper bits of the freeze register read as zero
        if (wr_freeze)
            freeze_reg <= {6'h00, w_data_reg[1:0]};
        if (wr_clkres)
            clkres_reg <= w_data_reg[7:0];
        // bit 7 of the start register is unused and reads zero
        if (wr_start)
            start_reg <= {1'b0, w_data_reg[6:0]};
    end
end

// ----------------------------------------------------------------
// axi read path
// ----------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;
assign rd_take = s_axi_arvalid && s_axi_arready;
assign rd_slot = slot_of(s_axi_araddr);

// read data is registered, answer one cycle after the address
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `ASC_RESP_OKAY;
    end else begin
        if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ASC_RESP_OKAY;
            case (rd_slot)
                4'h0: s_axi_rdata <= {24'h000000, freeze_reg};
                4'h1: s_axi_rdata <= {24'h000000, clkres_reg};
                4'h2: s_axi_rdata <= {24'h000000, start_reg};
                4'h3: s_axi_rdata <= {16'h0000, sequence_done_flag, 4'h0,
                    count_reg, result_done_flag}; // R23
                4'hF: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `ASC_RESP_SLVERR;
                end
                default: s_axi_rdata <= {16'h0000, result_reg[rd_slot[2:0] + 3'h4]};
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
// reserved code 01 falls through to the continue behaviour
assign frz_code = freeze_reg[`ASC_FRZ_HI:`ASC_FRZ_LO]; // R22
assign halt_now = background_debug_mode && frz_code == `ASC_FRZ_HALT; // R4
assign len = conv_len(clkres_reg[`ASC_TEN_BIT],
    clkres_reg[`ASC_SMP_HI:`ASC_SMP_LO]);
// the converter clock is frozen out of the count while halted
assign conv_end = state_reg == ST_RUN && conv_tick && !halt_now
    && clk_cnt_reg >= len - 6'h01; // R7 R4
assign last_conv = count_reg == (start_reg[`ASC_EIGHT] ? 3'h7 : 3'h3); // R13

// next state; any control write overrides the normal walk
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: state_next = ST_IDLE;
        ST_RUN: begin
            if (conv_end && last_conv && !start_reg[`ASC_REPEAT])
                state_next = ST_IDLE; // R14
            else if (conv_end && background_debug_mode
                && frz_code == `ASC_FRZ_FINISH)
                state_next = ST_PAUSE; // R3
        end
        ST_PAUSE: begin
            if (!background_debug_mode)
                state_next = ST_RUN; // R3
        end
        default: state_next = ST_IDLE;
    endcase
    if (wr_freeze)
        state_next = ST_IDLE; // R1
    if (wr_clkres)
        state_next = ST_IDLE; // R11
    if (wr_start)
        state_next = ST_RUN; // R12
end

// state, counters and channel choice
always @(posedge aclk) begin
    if (!aresetn) begin
        state_reg <= ST_IDLE;
        count_reg <= 3'h0;
        clk_cnt_reg <= 6'h00;
        conv_channel <= 4'h0;
        conv_busy <= 1'b0;
        conv_ten_bit <= 1'b0;
    end else begin
        state_reg <= state_next;
        conv_busy <= state_next == ST_RUN;
        conv_ten_bit <= clkres_reg[`ASC_TEN_BIT]; // R5
        if (wr_start || wr_freeze || wr_clkres) begin
            count_reg <= 3'h0;
            clk_cnt_reg <= 6'h00;
        end else if (conv_end) begin
            clk_cnt_reg <= 6'h00;
            // the counter wraps with the sequence length
            count_reg <= last_conv ? 3'h0 : count_reg + 3'h1; // R23
        end else if (state_reg == ST_RUN && conv_tick && !halt_now) begin
            clk_cnt_reg <= clk_cnt_reg + 6'h01; // R2
        end
        // channel follows the counter when stepping; codes map straight to inputs
        // 0-7, reserved 8-11 and references 12-15
        if (!start_reg[`ASC_STEP])
            conv_channel <= start_reg[`ASC_CH_HI:`ASC_CH_LO]; // R15 R17
        else if (start_reg[`ASC_EIGHT])
            conv_channel <= {start_reg[3], count_reg}; // R16 R18
        else
            conv_channel <= {start_reg[3:2], count_reg[1:0]}; // R16
    end
end

// ----------------------------------------------------------------
// results and flags
// ----------------------------------------------------------------
// reading a result clears its flag; a load in the same cycle wins
always @(posedge aclk) begin
    if (!aresetn) begin
        sequence_done_flag <= 1'b0;
        result_done_flag <= 8'h00;
        conv_capture <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            result_reg[i] <= 16'h0000;
    end else begin
        conv_capture <= conv_end;
        for (i = 0; i < 8; i = i + 1) begin
            if (wr_start)
                result_done_flag[i] <= 1'b0; // R12
            else if (conv_end && count_reg == i[2:0])
                result_done_flag[i] <= 1'b1; // R20
            else if (rd_take && rd_slot == i[3:0] + 4'h4)
                result_done_flag[i] <= 1'b0;
        end
        if (conv_end) begin
            // left justified; the 8-bit result keeps the top bits
            if (clkres_reg[`ASC_TEN_BIT])
                result_reg[count_reg] <= {conv_data, 6'h00}; // R21
            else
                result_reg[count_reg] <= {conv_data[9:2], 8'h00}; // R21
        end
        if (wr_start)
            sequence_done_flag <= 1'b0; // R12
        else if (conv_end && last_conv)
            sequence_done_flag <= 1'b1; // R19
    end
end

endmodule // asc_sequence_control

//--- verilog/asc_consts.vh
// constants for the converter sequence control block
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASC_OFF_FREEZE 6'h00
`define ASC_OFF_CLKRES 6'h04
`define ASC_OFF_START 6'h08
`define ASC_OFF_STATUS 6'h0C
`define ASC_OFF_RESULT0 6'h10
`define ASC_OFF_LAST 6'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASC_FRZ_HI 1
`define ASC_FRZ_LO 0
`define ASC_TEN_BIT 7
`define ASC_SMP_HI 6
`define ASC_SMP_LO 5
`define ASC_PRS_HI 4
`define ASC_PRS_LO 0
`define ASC_EIGHT 6
`define ASC_REPEAT 5
`define ASC_STEP 4
`define ASC_CH_HI 3
`define ASC_CH_LO 0
`define ASC_ST_SEQ 15
`define ASC_ST_CNT_HI 10
`define ASC_ST_CNT_LO 8

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define ASC_RST_FREEZE 8'h00
`define ASC_RST_CLKRES 8'h01
`define ASC_RST_START 8'h00
`define ASC_FRZ_FINISH 2'h2
`define ASC_FRZ_HALT 2'h3

// ----------------------------------------------------------------
// timing counts in converter clocks
// ----------------------------------------------------------------
`define ASC_BASE_8BIT 6'h10
`define ASC_BASE_10BIT 6'h12
`define ASC_SMP_MIN 6'h02

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2

`endif

//--- verilog/asc_prescaler.v
// modulo prescaler plus divide-by-two stage making the converter clock
`timescale 1ns/1ps
module asc_prescaler (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire [4:0] prescale,
    // converter clock outputs
    output reg conv_clk_reg,
    output reg conv_tick_reg
);

// ----------------------------------------------------------------
// modulo counter
// ----------------------------------------------------------------
reg [4:0] div_cnt_reg; // bus clocks since last half-period edge

// each half period lasts prescale+1 bus clocks, so the total
// divisor is 2*(prescale+1); the final toggle keeps duty at half
always @(posedge aclk) begin
    if (!aresetn) begin
        div_cnt_reg <= 5'h00;
        conv_clk_reg <= 1'b0;
        conv_tick_reg <= 1'b0;
    end else begin
        conv_tick_reg <= 1'b0;
        if (div_cnt_reg >= prescale) begin // R8
            // compare with >= so a smaller new value never overshoots
            div_cnt_reg <= 5'h00;
            conv_clk_reg <= ~conv_clk_reg; // R8
            // one tick per full converter period, on its rising edge
            conv_tick_reg <= ~conv_clk_reg; // R9
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end
end

endmodule // asc_prescaler

//--- verilog/asc_fix_note.v
// spare file: the sequence block needs no third module

//--- tb/asc_seq_properties.sv
// concurrent checks on the ports of the converter sequence control block
`timescale 1ns/1ps
module asc_seq_properties (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // debug and converter side
    input wire background_debug_mode,
    input wire conv_busy,
    input wire conv_ten_bit,
    input wire conv_capture,
    input wire sequence_done_flag,
    input wire [7:0] result_done_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    // only writes whose address and data land on one edge are tracked
    wire wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
    reg [1:0] frz_reg; // shadow of the freeze code
    always @(posedge aclk) begin
        if (!aresetn) begin
            frz_reg <= 2'h0;
        end else if (wr_go && s_axi_awaddr == 6'h00) begin
            frz_reg <= s_axi_wdata[1:0];
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    start_clear_a: assert property (wr_go && s_axi_awaddr == 6'h08 |-> ##2
        result_done_flag == 8'h00 && !sequence_done_flag && conv_busy)
        else $error("start did not restart cleanly");
    freeze_abort_a: assert property (wr_go && s_axi_awaddr == 6'h00 |-> ##2 !conv_busy)
        else $error("freeze write left sequencer running");
    clkres_abort_a: assert property (wr_go && s_axi_awaddr == 6'h04 |->
        ##2 !conv_busy ##1 !conv_busy) else $error("clock write left sequencer running");
    ten_bit_a: assert property (wr_go && s_axi_awaddr == 6'h04 |->
        ##3 conv_ten_bit == $past(s_axi_wdata[7], 3)) else $error("resolution not applied");
    capture_pulse_a: assert property (conv_capture |=> !conv_capture)
        else $error("capture longer than one cycle");
    halt_debug_a: assert property (background_debug_mode && $past(background_debug_mode)
        && frz_reg == 2'h3 |-> !conv_capture) else $error("result stored while halted");
    seq_end_a: assert property ($rose(sequence_done_flag) |->
        result_done_flag[3] || result_done_flag[7]) else $error("sequence flag before last result");
endmodule // asc_seq_properties

bind asc_sequence_control asc_seq_properties asc_seq_properties_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .background_debug_mode, .conv_busy, .conv_ten_bit, .conv_capture,
    .sequence_done_flag, .result_done_flag
);

//--- tb/asc_conv_model.sv
// behavioural converter core returning a channel-tagged sample
`timescale 1ns/1ps
module asc_conv_model (
    // converter side of the block
    input wire conv_clk,
    input wire [3:0] conv_channel,
    // sample handed back
    output logic [9:0] conv_data
);
    // ----------------------------------------------------------------
    // sample path
    // ----------------------------------------------------------------
    // follows the converter clock, so a late channel change shows as a wrong sample
    always @(posedge conv_clk) begin
        conv_data <= {conv_channel, 6'h15};
    end
endmodule // asc_conv_model

//--- tb/testbench.sv
// self-checking bench for the converter sequence control block
`timescale 1ns/1ps
module testbench;
    // bus and control inputs
    logic aclk, aresetn, background_debug_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    // design outputs
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [9:0] conv_data;
    wire [3:0] conv_channel;
    wire conv_clk, conv_busy, conv_ten_bit, conv_capture, sequence_done_flag;
    wire [7:0] result_done_flag;
    // bookkeeping
    integer n_mismatch, cmp_count, cyc, n_cap, last_cap, cap_gap, last_clk, clk_gap;
    integer t, n, base;
    logic [15:0] rows [0:4]; // clock/resolution byte beside start byte
    logic [7:0] c4, c5;
    logic [3:0] ch, k;
    logic [31:0] d;
    logic [1:0] r;

    asc_sequence_control asc_sequence_control_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .background_debug_mode, .conv_data,
        .conv_clk, .conv_busy, .conv_channel, .conv_ten_bit, .conv_capture,
        .sequence_done_flag, .result_done_flag);
    asc_conv_model asc_conv_model_inst (.conv_clk, .conv_channel, .conv_data);

    // ----------------------------------------------------------------
    // monitors: stored results and converter clock spacing
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (conv_capture) begin
            n_cap <= n_cap + 1;
            cap_gap <= cyc - last_cap;
            last_cap <= cyc;
        end
    end
    always @(posedge conv_clk) begin
        clk_gap <= ($time - last_clk) / 5;
        last_clk <= $time;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // a wait that runs out is a mismatch and ends the run
    task hang;
        begin
            check(32'h0, 32'h1);
            results;
        end
    endtask
    // readies are sampled mid-cycle, where they have settled for the coming edge
    // each call first lets an edge pass, so back-to-back calls never retoggle a ready
    task wr(input [5:0] a, input [31:0] v, input [3:0] s, output [1:0] rs);
        integer i;
        logic ta, tw, tb;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            tb = 1'b0;
            for (i = 0; i < 40 && !tb; i = i + 1) begin
                @(negedge aclk);
                ta = s_axi_awvalid & s_axi_awready;
                tw = s_axi_wvalid & s_axi_wready;
                tb = s_axi_bvalid;
                rs = s_axi_bresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (tb) s_axi_bready <= 1'b0;
            end
            if (!tb) hang;
        end
    endtask
    task rd(input [5:0] a, output [31:0] v, output [1:0] rs);
        integer i;
        logic ta, tr;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            tr = 1'b0;
            for (i = 0; i < 40 && !tr; i = i + 1) begin
                @(negedge aclk);
                ta = s_axi_arvalid & s_axi_arready;
                tr = s_axi_rvalid;
                v = s_axi_rdata;
                rs = s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
                if (tr) s_axi_rready <= 1'b0;
            end
            if (!tr) hang;
        end
    endtask
    task rchk(input [5:0] a, input [31:0] e);
        begin
            rd(a, d, r);
            check(d, e);
        end
    endtask
    task wait_cap(input integer target, input integer lim);
        integer i;
        begin
            for (i = 0; i < lim && n_cap < target; i = i + 1) @(posedge aclk);
            if (n_cap < target) hang;
        end
    endtask

    // ----------------------------------------------------------------
    // clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, background_debug_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 18'h0;
        s_axi_wdata = 32'h0;
        {n_mismatch, cmp_count, cyc, n_cap, last_cap, cap_gap, last_clk, clk_gap} = 256'h0;
        rows[0] = 16'h0005;
        rows[1] = 16'hA114;
        rows[2] = 16'h405C;
        rows[3] = 16'hE34C;
        rows[4] = 16'h0250;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, refused places and a write with the low byte off
        rchk(6'h04, 32'h01);
        rchk(6'h00, 32'h00);
        rchk(6'h08, 32'h00);
        rchk(6'h0C, 32'h00);
        rchk(6'h30, 32'h00);
        check(r, 2'h2);
        wr(6'h0C, 32'h01, 4'hF, r);
        check(r, 2'h2);
        wr(6'h04, 32'hFF, 4'h0, r);
        rchk(6'h04, 32'h01);
        $display("test reset and map done");
        // table of sequences: timing, channel walk and stored values
        for (t = 0; t < 5; t = t + 1) begin
            c4 = rows[t][15:8];
            c5 = rows[t][7:0];
            n = c5[6] ? 8 : 4;
            wr(6'h04, {24'h0, c4}, 4'hF, r);
            base = n_cap;
            wr(6'h08, {24'h0, c5}, 4'hF, r);
            wait_cap(base + n, 20000);
            rchk(6'h0C, {16'h8000 | (n == 8 ? 16'hFF : 16'h0F)});
            check(cap_gap, ((c4[7] ? 18 : 16) + (2 << c4[6:5])) * 2 * (c4[4:0] + 1));
            check(clk_gap, 2 * (c4[4:0] + 1));
            for (k = 0; k < n; k = k + 1) begin
                ch = c5[4] ? (n == 8 ? {c5[3], k[2:0]} : {c5[3:2], k[1:0]}) : c5[3:0];
                rchk(6'h10 + {k, 2'h0}, c4[7] ? {ch, 12'h540} : {ch, 12'h500});
            end
            rchk(6'h0C, 32'h8000);
            $display("test row %0d done", t);
        end
        // repeating sequences, then a clock write stops them
        base = n_cap;
        wr(6'h08, 32'h20, 4'hF, r);
        wait_cap(base + 6, 5000);
        check(conv_busy, 1'b1);
        check(sequence_done_flag, 1'b1);
        wr(6'h04, 32'h00, 4'hF, r);
        repeat (3) @(posedge aclk);
        base = n_cap;
        repeat (200) @(posedge aclk);
        check(n_cap - base, 0);
        $display("test repeat and abort done");
        // restart in mid-run, then freeze write abort
        base = n_cap;
        wr(6'h08, 32'h01, 4'hF, r);
        wait_cap(base + 2, 2000);
        wr(6'h08, 32'h01, 4'hF, r);
        rchk(6'h0C, 32'h00);
        wr(6'h00, 32'h00, 4'hF, r);
        check(conv_busy, 1'b0);
        $display("test restart done");
        // debug response for every freeze code
        for (k = 0; k < 4; k = k + 1) begin
            wr(6'h00, {28'h0, k}, 4'hF, r);
            base = n_cap;
            wr(6'h08, 32'h03, 4'hF, r);
            repeat (10) @(posedge aclk);
            background_debug_mode <= 1'b1;
            repeat (120) @(posedge aclk);
            check(n_cap - base, k == 3 ? 0 : (k == 2 ? 1 : 3));
            background_debug_mode <= 1'b0;
            wait_cap(base + 4, 1000);
            rchk(6'h0C, 32'h800F);
        end
        $display("test debug codes done");
        results;
    end
endmodule // testbench
